/* File: common/vsgs_pkg.sv */
// vector sequencer group sync: constants and carrier types
// assumes one 200 MHz clock and a plain strobe register port
//
// Overview of operation
// R1 - loop on jump while watched compare passes
// R2 - fail falls through past jump sequence
// R3 - seven sequences before jump prepare it
// R4 - domain compares touch only overall state
// R5 - overlapping domains raise an error event
// R6 - erase-program clears all conditional jumps
// R7 - program enters domains only linearly
// R8 - protocol start waits for selected edge
// R9 - protocol group mode ignores start command
// R10 - end sequence stops execution internally
// R11 - controller stops looping test before reading
// R12 - group acts as one large tester
// R13 - any member fail fails the group
// R14 - controller programs jumps identically everywhere
// R15 - commander starts, stops, reports pause/done
// R16 - controls go to commander, others member
// R17 - controller queries state after arming
// R18 - commander redistributes external clock on backplane
// R19 - export option drives front clock out
// R20 - recalibrate skew when group changes
// R21 - internal clocks set to same rate
// R22 - watched result latched before domain
`default_nettype none
package vsgs_pkg;
    localparam int VSGS_SEQ_W = 8;
    localparam int VSGS_JMP_N = 4;
    localparam int VSGS_PREP_LEN = 7;
    // register offsets
    localparam logic [3:0] VSGS_REG_CTRL = 4'h0;
    localparam logic [3:0] VSGS_REG_CMD = 4'h1;
    localparam logic [3:0] VSGS_REG_ENDSEQ = 4'h2;
    localparam logic [3:0] VSGS_REG_JMP = 4'h3;
    localparam logic [3:0] VSGS_REG_STATUS = 4'h4;
    localparam logic [3:0] VSGS_REG_SEQ = 4'h5;
    // command bits
    localparam int VSGS_CMD_START = 0;
    localparam int VSGS_CMD_STOP = 1;
    localparam int VSGS_CMD_HOLD = 2;
    localparam int VSGS_CMD_CONT = 3;
    localparam int VSGS_CMD_ARM = 4;
    localparam int VSGS_CMD_ERASE = 5;
    localparam int VSGS_CMD_CLRSTATE = 6;
    localparam int VSGS_CMD_ERRCLR = 7;
    localparam logic [15:0] VSGS_CTRL_RST = 16'h0000;
    localparam logic [VSGS_SEQ_W-1:0] VSGS_END_RST = 8'hFF;

    typedef enum logic [1:0] {
        VSGS_ROLE_SINGLE = 2'b00,
        VSGS_ROLE_COMMANDER = 2'b01,
        VSGS_ROLE_MEMBER = 2'b10,
        VSGS_ROLE_STST = 2'b11
    } vsgs_role_e;

    typedef enum logic [2:0] {
        VSGS_ST_IDLE = 3'b000,
        VSGS_ST_ARMED = 3'b001,
        VSGS_ST_RUN = 3'b010,
        VSGS_ST_HOLD = 3'b011,
        VSGS_ST_DONE = 3'b100
    } vsgs_state_e;

    typedef struct packed {
        logic valid;
        logic [VSGS_SEQ_W-1:0] at;
        logic [VSGS_SEQ_W-1:0] target;
    } vsgs_jump_s;

    typedef struct packed {
        logic step;
        logic [1:0] clk_sel;
        vsgs_role_e role;
    } vsgs_ctrl_s;
endpackage
`default_nettype wire

/* File: rtl/vsgs_top.sv */
// vector sequencer control: jumps, start/stop protocol, grouping, clock select
// assumes vector memory and pin logic outside; compare results arrive per sequence tick
//
// Decided for this implementation: strobed register access and the register offsets.
`default_nettype none
module vsgs_top
    import vsgs_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // sequence timing and compare from pin logic
    input wire logic seq_tick,
    input wire logic cmp_valid,
    input wire logic cmp_fail,
    // backplane and front clock pins
    input wire logic stst_start_pin,
    input wire logic stst_stop_pin,
    input wire logic clk10_edge_pin,
    input wire logic group_fail_pin,
    output logic group_fail_out,
    output logic group_fail_oe,
    input wire logic front_clk_pin,
    input wire logic ecl_clk_pin,
    output logic ecl_clk_out,
    output logic ecl_clk_oe,
    output logic seq_clk_out,
    // sequencer outputs
    output logic [VSGS_SEQ_W-1:0] seq_addr,
    output logic running,
    output logic hold_evt,
    output logic done_evt,
    output logic err_evt
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic [5:0] sync3_r;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1_r <= 6'h00;
            sync2_r <= 6'h00;
            sync3_r <= 6'h00;
        end else begin
            sync1_r <= {ecl_clk_pin, front_clk_pin, group_fail_pin, clk10_edge_pin, stst_stop_pin, stst_start_pin};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end
    logic stst_start_s;
    logic stst_stop_s;
    logic clk10_rise;
    logic peer_fail_s;
    assign stst_start_s = sync2_r[0];
    assign stst_stop_s = sync2_r[1];
    assign clk10_rise = sync2_r[2] & ~sync3_r[2];
    assign peer_fail_s = sync2_r[3];

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        vsgs_ctrl_s ctrl;
        vsgs_state_e st;
        logic [VSGS_SEQ_W-1:0] endseq;
        logic [VSGS_SEQ_W-1:0] seq;
        vsgs_jump_s [VSGS_JMP_N-1:0] jmp;
        logic [1:0] jsel;
        logic jfail;
        logic latched;
        logic test_fail;
        logic stst_pend;
        logic err;
        logic hold_p;
        logic done_p;
        logic err_p;
        logic [15:0] rdata;
        logic fail_out;
        logic eclk;
        logic sclk;
        logic run;
        logic eoe;
    } vsgs_state_s;

    vsgs_state_s s_r;
    vsgs_state_s s_nxt;

    function automatic logic in_domain(input logic [VSGS_SEQ_W-1:0] q, input vsgs_jump_s j);
        logic [VSGS_SEQ_W:0] lo;
        lo = {1'b0, j.at} - (VSGS_SEQ_W+1)'(VSGS_PREP_LEN);
        return j.valid && ({1'b0, q} < {1'b0, j.at}) && ({1'b0, q} >= lo || lo[VSGS_SEQ_W]);
    endfunction

    function automatic logic overlap(input logic [VSGS_SEQ_W-1:0] a, input logic [VSGS_SEQ_W-1:0] b);
        logic [VSGS_SEQ_W:0] d;
        d = (a > b) ? ({1'b0, a} - {1'b0, b}) : ({1'b0, b} - {1'b0, a});
        return d <= (VSGS_SEQ_W+1)'(VSGS_PREP_LEN);
    endfunction

    logic wr_cmd;
    logic stst_mode;
    logic any_fail;
    logic [VSGS_JMP_N-1:0] hit;
    logic [VSGS_JMP_N-1:0] dom;
    logic [VSGS_JMP_N-1:0] clash;
    logic [VSGS_JMP_N-1:0] free_slot;

    genvar gi;
    generate
        for (gi = 0; gi < VSGS_JMP_N; gi++) begin : g_jmp
            assign hit[gi] = s_r.jmp[gi].valid && (s_r.jmp[gi].at == s_r.seq);
            // R3 domain of seven
            assign dom[gi] = in_domain(s_r.seq, s_r.jmp[gi]);
            // R5 overlap check
            assign clash[gi] = s_r.jmp[gi].valid && overlap(s_r.jmp[gi].at, reg_wdata[VSGS_SEQ_W-1:0]);
            assign free_slot[gi] = ~s_r.jmp[gi].valid;
        end
    endgenerate

    assign wr_cmd = reg_wr && (reg_addr == VSGS_REG_CMD);
    assign stst_mode = (s_r.ctrl.role == VSGS_ROLE_STST);
    // R13 shared group fail
    assign any_fail = s_r.test_fail | peer_fail_s;

    always_comb begin
        s_nxt = s_r;
        s_nxt.hold_p = 1'b0;
        s_nxt.done_p = 1'b0;
        s_nxt.err_p = 1'b0;
        s_nxt.rdata = 16'h0000;
        s_nxt.fail_out = s_r.test_fail;
        // R19 export front clock
        s_nxt.eclk = sync2_r[4];
        // R18 clock select
        case (s_r.ctrl.clk_sel)
            2'b01: s_nxt.sclk = sync2_r[4];
            2'b10: s_nxt.sclk = sync2_r[5];
            default: s_nxt.sclk = seq_tick;
        endcase
        if (reg_wr && reg_addr == VSGS_REG_CTRL) begin
            s_nxt.ctrl = vsgs_ctrl_s'(reg_wdata[4:0]);
        end
        if (reg_wr && reg_addr == VSGS_REG_ENDSEQ) begin
            s_nxt.endseq = reg_wdata[VSGS_SEQ_W-1:0];
        end
        if (reg_wr && reg_addr == VSGS_REG_JMP) begin
            // R5 overlap error
            if (|clash || ~|free_slot) begin
                s_nxt.err = 1'b1;
                s_nxt.err_p = 1'b1;
            end else begin
                for (int i = VSGS_JMP_N-1; i >= 0; i--) begin
                    if (free_slot[i]) begin
                        s_nxt.jsel = 2'(i);
                    end
                end
                s_nxt.jmp[s_nxt.jsel].valid = 1'b1;
                s_nxt.jmp[s_nxt.jsel].at = reg_wdata[VSGS_SEQ_W-1:0];
                s_nxt.jmp[s_nxt.jsel].target = reg_wdata[15:VSGS_SEQ_W];
            end
        end
        if (wr_cmd) begin
            // R6 erase clears jumps
            if (reg_wdata[VSGS_CMD_ERASE]) begin
                for (int i = 0; i < VSGS_JMP_N; i++) begin
                    s_nxt.jmp[i].valid = 1'b0;
                end
            end
            if (reg_wdata[VSGS_CMD_CLRSTATE]) begin
                s_nxt.test_fail = 1'b0;
            end
            if (reg_wdata[VSGS_CMD_ERRCLR]) begin
                s_nxt.err = 1'b0;
            end
            if (reg_wdata[VSGS_CMD_ARM] && s_r.st != VSGS_ST_RUN) begin
                s_nxt.st = VSGS_ST_ARMED;
                s_nxt.seq = '0;
                s_nxt.latched = 1'b0;
                s_nxt.stst_pend = 1'b0;
            end
        end
        // compare results: set wins over clear
        if (cmp_valid && cmp_fail) begin
            s_nxt.test_fail = 1'b1;
        end
        // R22 latch before domain
        if (cmp_valid && !(|dom) && !(|hit)) begin
            s_nxt.jfail = cmp_fail;
            s_nxt.latched = 1'b1;
        end
        // R8 protocol start waits for clk10 edge
        if (stst_mode && s_r.st == VSGS_ST_ARMED && stst_start_s) begin
            s_nxt.stst_pend = 1'b1;
        end
        case (s_r.st)
            VSGS_ST_ARMED: begin
                // R12 members ignore the start command
                // R9 start command ignored in protocol mode
                if (!stst_mode && wr_cmd && reg_wdata[VSGS_CMD_START] && s_r.ctrl.role != VSGS_ROLE_MEMBER) begin
                    s_nxt.st = VSGS_ST_RUN;
                end else if (s_r.stst_pend && clk10_rise) begin
                    s_nxt.st = VSGS_ST_RUN;
                    s_nxt.stst_pend = 1'b0;
                end
            end
            VSGS_ST_RUN: begin
                // R15 commander stop and hold
                if ((wr_cmd && reg_wdata[VSGS_CMD_STOP]) || (stst_mode && stst_stop_s)) begin
                    s_nxt.st = VSGS_ST_DONE;
                    s_nxt.done_p = 1'b1;
                end else if (wr_cmd && reg_wdata[VSGS_CMD_HOLD]) begin
                    s_nxt.st = VSGS_ST_HOLD;
                    s_nxt.hold_p = 1'b1;
                end else if (seq_tick) begin
                    // R10 end sequence stops
                    if (s_r.seq == s_r.endseq) begin
                        s_nxt.st = VSGS_ST_DONE;
                        s_nxt.done_p = 1'b1;
                    end else begin
                        s_nxt.seq = s_r.seq + 1'b1;
                        for (int i = 0; i < VSGS_JMP_N; i++) begin
                            // R1 R2 take jump on pass, fall through on fail
                            if (hit[i] && !s_r.jfail) begin
                                s_nxt.seq = s_r.jmp[i].target;
                            end
                        end
                        if (s_r.ctrl.step) begin
                            s_nxt.st = VSGS_ST_HOLD;
                            s_nxt.hold_p = 1'b1;
                        end
                    end
                end
            end
            VSGS_ST_HOLD: begin
                if (wr_cmd && reg_wdata[VSGS_CMD_STOP]) begin
                    s_nxt.st = VSGS_ST_DONE;
                    s_nxt.done_p = 1'b1;
                end else if (wr_cmd && reg_wdata[VSGS_CMD_CONT]) begin
                    s_nxt.st = VSGS_ST_RUN;
                end
            end
            VSGS_ST_IDLE, VSGS_ST_DONE: begin
            end
            default: s_nxt.st = VSGS_ST_IDLE;
        endcase
        if (reg_rd) begin
            case (reg_addr)
                VSGS_REG_CTRL: s_nxt.rdata = {11'h000, s_r.ctrl};
                VSGS_REG_ENDSEQ: s_nxt.rdata = {8'h00, s_r.endseq};
                VSGS_REG_STATUS: s_nxt.rdata = {10'h000, s_r.err, any_fail, s_r.latched, s_r.st};
                VSGS_REG_SEQ: s_nxt.rdata = {8'h00, s_r.seq};
                default: s_nxt.rdata = 16'h0000;
            endcase
        end
        // registered copies of level outputs
        s_nxt.run = (s_nxt.st == VSGS_ST_RUN);
        s_nxt.eoe = (s_nxt.ctrl.clk_sel == 2'b01);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.ctrl <= vsgs_ctrl_s'(VSGS_CTRL_RST[4:0]);
            s_r.endseq <= VSGS_END_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata = s_r.rdata;
    assign seq_addr = s_r.seq;
    assign running = s_r.run;
    assign hold_evt = s_r.hold_p;
    assign done_evt = s_r.done_p;
    assign err_evt = s_r.err_p;
    assign group_fail_out = s_r.fail_out;
    assign group_fail_oe = s_r.fail_out;
    assign ecl_clk_out = s_r.eclk;
    assign ecl_clk_oe = s_r.eoe;
    assign seq_clk_out = s_r.sclk;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_end_stop;
        @(posedge sys_clk) disable iff (rst)
        (running && seq_tick && seq_addr == s_r.endseq && !wr_cmd && !stst_mode) |=> (done_evt && !running);
    endproperty
    a_end_stop: assert property (p_end_stop) else $error("end sequence did not stop"); // R10

    property p_erase;
        @(posedge sys_clk) disable iff (rst)
        (wr_cmd && reg_wdata[VSGS_CMD_ERASE]) |=> (&free_slot);
    endproperty
    a_erase: assert property (p_erase) else $error("erase left a jump"); // R6

    property p_overlap;
        @(posedge sys_clk) disable iff (rst)
        (reg_wr && reg_addr == VSGS_REG_JMP && |clash) |=> (err_evt && s_r.err);
    endproperty
    a_overlap: assert property (p_overlap) else $error("overlap not flagged"); // R5

    property p_pass_jump;
        @(posedge sys_clk) disable iff (rst)
        (running && seq_tick && hit[0] && !s_r.jfail && seq_addr != s_r.endseq && !wr_cmd && !stst_mode)
        |=> seq_addr == $past(s_r.jmp[0].target);
    endproperty
    a_pass_jump: assert property (p_pass_jump) else $error("jump not taken"); // R1

    property p_fail_fall;
        @(posedge sys_clk) disable iff (rst)
        (running && seq_tick && hit[0] && s_r.jfail && seq_addr != s_r.endseq && !wr_cmd && !stst_mode)
        |=> seq_addr == $past(seq_addr) + 1'b1;
    endproperty
    a_fail_fall: assert property (p_fail_fall) else $error("fail took jump"); // R2

    property p_latch_hold;
        @(posedge sys_clk) disable iff (rst)
        (|dom) |=> (s_r.jfail == $past(s_r.jfail));
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched result moved"); // R22 R4

    property p_no_cmd_start;
        @(posedge sys_clk) disable iff (rst)
        (stst_mode && s_r.st == VSGS_ST_ARMED && !s_r.stst_pend) |=> !running;
    endproperty
    a_no_cmd_start: assert property (p_no_cmd_start) else $error("protocol mode started early"); // R9 R8

    property p_stst_edge;
        @(posedge sys_clk) disable iff (rst)
        (stst_mode && s_r.st == VSGS_ST_ARMED && !clk10_rise) |=> !running;
    endproperty
    a_stst_edge: assert property (p_stst_edge) else $error("protocol start off the clock edge"); // R8

    property p_group_fail;
        @(posedge sys_clk) disable iff (rst)
        (cmp_valid && cmp_fail) |=> s_r.test_fail ##1 group_fail_out;
    endproperty
    a_group_fail: assert property (p_group_fail) else $error("fail not recorded"); // R13
endmodule
`default_nettype wire

/* File: tb/vsgs_peer.sv */
// slot-0 and group peer model: clk10, start/stop lines, wired fail line, ecl line
// assumes one bench clock; bench pulses go and halt and holds peer_fail as a level
`default_nettype none
module vsgs_peer (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // bench commands
    input wire logic go,
    input wire logic halt,
    input wire logic peer_fail,
    // device side
    input wire logic fail_out,
    input wire logic fail_oe,
    input wire logic ecl_out,
    input wire logic ecl_oe,
    output logic stst_start_pin,
    output logic stst_stop_pin,
    output logic clk10_edge_pin,
    output logic group_fail_pin,
    output logic front_clk_pin,
    output logic ecl_clk_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int c10 = 0;
    int cf = 0;
    int n_go = 0;
    int n_halt = 0;
    logic pat = 1'b0;
    logic c10_lvl = 1'b0;
    logic fc_lvl = 1'b0;
    always @(posedge sys_clk) begin
        c10 <= (c10 == 9) ? 0 : c10 + 1;
        if (c10 == 9) c10_lvl <= ~c10_lvl;
        cf <= (cf == 3) ? 0 : cf + 1;
        if (cf == 3) fc_lvl <= ~fc_lvl;
        pat <= ~pat;
        n_go <= rst ? 0 : (go ? 30 : (n_go > 0 ? n_go - 1 : 0));
        n_halt <= rst ? 0 : (halt ? 30 : (n_halt > 0 ? n_halt - 1 : 0));
    end
    assign clk10_edge_pin = c10_lvl;
    assign front_clk_pin = fc_lvl;
    assign stst_start_pin = (n_go > 0);
    assign stst_stop_pin = (n_halt > 0);
    assign group_fail_pin = (fail_oe & fail_out) | peer_fail;
    // released ecl line never holds a value
    assign ecl_clk_pin = ecl_oe ? ecl_out : pat;
endmodule
`default_nettype wire

/* File: tb/vsgs_top_test.sv */
// testbench for vsgs_top: one task per scenario over the register port
// assumes vsgs_peer stands for slot-0 and the group peers
`default_nettype none
module vsgs_top_test import vsgs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst, reg_wr, reg_rd, seq_tick, cmp_valid, cmp_fail, peer_go, peer_halt, peer_fail;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic stst_start_pin, stst_stop_pin, clk10_edge_pin, group_fail_pin, group_fail_out, group_fail_oe;
    logic front_clk_pin, ecl_clk_pin, ecl_clk_out, ecl_clk_oe, seq_clk_out, running, hold_evt, done_evt, err_evt;
    logic [VSGS_SEQ_W-1:0] seq_addr;
    int n_mismatch = 0, compares = 0, n_done = 0, n_hold = 0, n_err = 0, c10 = 0, k;
    logic c10_d = 1'b0;
    vsgs_top u_vsgs_top (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .seq_tick(seq_tick), .cmp_valid(cmp_valid),
        .cmp_fail(cmp_fail), .stst_start_pin(stst_start_pin), .stst_stop_pin(stst_stop_pin),
        .clk10_edge_pin(clk10_edge_pin), .group_fail_pin(group_fail_pin), .group_fail_out(group_fail_out),
        .group_fail_oe(group_fail_oe), .front_clk_pin(front_clk_pin), .ecl_clk_pin(ecl_clk_pin),
        .ecl_clk_out(ecl_clk_out), .ecl_clk_oe(ecl_clk_oe), .seq_clk_out(seq_clk_out), .seq_addr(seq_addr),
        .running(running), .hold_evt(hold_evt), .done_evt(done_evt), .err_evt(err_evt));
    vsgs_peer u_vsgs_peer (.sys_clk(sys_clk), .rst(rst), .go(peer_go), .halt(peer_halt), .peer_fail(peer_fail),
        .fail_out(group_fail_out), .fail_oe(group_fail_oe), .ecl_out(ecl_clk_out), .ecl_oe(ecl_clk_oe),
        .stst_start_pin(stst_start_pin), .stst_stop_pin(stst_stop_pin), .clk10_edge_pin(clk10_edge_pin),
        .group_fail_pin(group_fail_pin), .front_clk_pin(front_clk_pin), .ecl_clk_pin(ecl_clk_pin));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // ----------------------------------------
    // event counters
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (done_evt === 1'b1) n_done++;
        if (hold_evt === 1'b1) n_hold++;
        if (err_evt === 1'b1) n_err++;
        c10_d <= clk10_edge_pin;
        c10 <= (clk10_edge_pin === 1'b1 && c10_d === 1'b0) ? 0 : c10 + 1;
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic cmd(input int b);
        wr(VSGS_REG_CMD, 16'h0001 << b);
    endtask
    task automatic tk(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            seq_tick <= 1'b1;
            @(posedge sys_clk);
            seq_tick <= 1'b0;
            repeat (2) @(posedge sys_clk);
        end
    endtask
    task automatic cm(input logic f);
        @(posedge sys_clk);
        cmp_valid <= 1'b1;
        cmp_fail <= f;
        @(posedge sys_clk);
        cmp_valid <= 1'b0;
        cmp_fail <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic wait_run(input logic v);
        for (k = 0; k < 300 && running !== v; k++) begin
            @(posedge sys_clk);
            #1;
        end
    endtask
    task automatic rs();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
    endtask
    task automatic go(input logic [15:0] c);
        wr(VSGS_REG_ENDSEQ, 16'h0014);
        wr(VSGS_REG_CTRL, c);
        cmd(VSGS_CMD_ARM);
        rd(VSGS_REG_STATUS);
        chk("armed", 16'h0001, d[2:0]);
        cmd(VSGS_CMD_START);
        wait_run(1'b1);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        rd(VSGS_REG_CTRL);
        chk("ctrl", 16'h0000, d);
        rd(VSGS_REG_ENDSEQ);
        chk("endseq", 16'h00FF, d);
        rd(VSGS_REG_STATUS);
        chk("status", 16'h0000, d);
        rd(4'hF);
        chk("unmapped", 16'h0000, d);
        $display("test regs done");
    endtask
    task automatic t_jump();
        int n0;
        rs();
        wr(VSGS_REG_JMP, 16'h000A);
        go(16'h0000);
        cm(1'b0);
        tk(5);
        cm(1'b1);
        tk(6);
        chk("loop back", 16'h0000, seq_addr);
        rd(VSGS_REG_STATUS);
        chk("state fail", 16'h0001, d[4]);
        chk("latched", 16'h0001, d[3]);
        chk("fail oe", 16'h0001, group_fail_oe);
        chk("fail out", 16'h0001, group_fail_out);
        cmd(VSGS_CMD_CLRSTATE);
        tk(2);
        cm(1'b1);
        tk(1);
        cm(1'b0);
        tk(8);
        chk("fall through", 16'h000B, seq_addr);
        rd(VSGS_REG_SEQ);
        chk("seq reg", 16'h000B, d);
        n0 = n_done;
        tk(10);
        chk("done evt", n0 + 1, n_done);
        chk("stopped", 16'h0000, running);
        $display("test jump done");
    endtask
    task automatic t_err();
        int n0;
        rs();
        n0 = n_err;
        wr(VSGS_REG_JMP, 16'h000A);
        wr(VSGS_REG_JMP, 16'h0011);
        repeat (3) @(posedge sys_clk);
        chk("overlap err", n0 + 1, n_err);
        rd(VSGS_REG_STATUS);
        chk("err flag", 16'h0001, d[5]);
        wr(VSGS_REG_JMP, 16'h0012);
        cmd(VSGS_CMD_ERASE);
        cmd(VSGS_CMD_ERRCLR);
        wr(VSGS_REG_JMP, 16'h000E);
        repeat (3) @(posedge sys_clk);
        chk("erase err", n0 + 1, n_err);
        rd(VSGS_REG_STATUS);
        chk("err clear", 16'h0000, d[5]);
        wr(VSGS_REG_JMP, 16'h001E);
        wr(VSGS_REG_JMP, 16'h002E);
        wr(VSGS_REG_JMP, 16'h003E);
        wr(VSGS_REG_JMP, 16'h004E);
        repeat (3) @(posedge sys_clk);
        chk("slots full", n0 + 2, n_err);
        $display("test err done");
    endtask
    task automatic t_stst();
        rs();
        wr(VSGS_REG_CTRL, 16'h0003);
        cmd(VSGS_CMD_ARM);
        cmd(VSGS_CMD_START);
        repeat (10) @(posedge sys_clk);
        chk("start cmd", 16'h0000, running);
        peer_go <= 1'b1;
        @(posedge sys_clk);
        peer_go <= 1'b0;
        wait_run(1'b1);
        chk("edge aligned", 16'h0001, running === 1'b1 && c10 >= 2 && c10 <= 9);
        peer_halt <= 1'b1;
        @(posedge sys_clk);
        peer_halt <= 1'b0;
        wait_run(1'b0);
        chk("stst stop", 16'h0000, running);
        cmd(VSGS_CMD_STOP);
        $display("test stst done");
    endtask
    task automatic t_group();
        int h0;
        rs();
        wr(VSGS_REG_CTRL, 16'h0002);
        cmd(VSGS_CMD_ARM);
        cmd(VSGS_CMD_START);
        repeat (10) @(posedge sys_clk);
        chk("member start", 16'h0000, running);
        rs();
        go(16'h0001);
        chk("cmdr start", 16'h0001, running);
        h0 = n_hold;
        cmd(VSGS_CMD_HOLD);
        repeat (3) @(posedge sys_clk);
        chk("hold evt", h0 + 1, n_hold);
        rd(VSGS_REG_STATUS);
        chk("hold state", 16'h0003, d[2:0]);
        cmd(VSGS_CMD_CONT);
        peer_fail <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rd(VSGS_REG_STATUS);
        chk("group fail", 16'h0001, d[4]);
        wr(VSGS_REG_CTRL, 16'h0011);
        h0 = n_hold;
        tk(1);
        chk("step hold", h0 + 1, n_hold);
        peer_fail <= 1'b0;
        cmd(VSGS_CMD_STOP);
        $display("test group done");
    endtask
    task automatic tog(output int ne, output int ns);
        logic le, ls;
        ne = 0;
        ns = 0;
        le = ecl_clk_out;
        ls = seq_clk_out;
        repeat (40) begin
            @(posedge sys_clk);
            #1;
            if (ecl_clk_out !== le) ne++;
            if (seq_clk_out !== ls) ns++;
            le = ecl_clk_out;
            ls = seq_clk_out;
        end
    endtask
    task automatic t_clock();
        int ne, ns;
        rs();
        wr(VSGS_REG_CTRL, 16'h0004);
        repeat (6) @(posedge sys_clk);
        #1 chk("ecl oe", 16'h0001, ecl_clk_oe);
        tog(ne, ns);
        chk("ecl toggles", 16'h000A, ne);
        chk("seq clk toggles", 16'h000A, ns);
        wr(VSGS_REG_CTRL, 16'h0008);
        repeat (3) @(posedge sys_clk);
        #1 chk("ecl released", 16'h0000, ecl_clk_oe);
        tog(ne, ns);
        chk("member clk toggles", 16'h0028, ns);
        $display("test clock done");
    endtask
    task automatic conclude();
        $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        conclude();
    end
    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, seq_tick, cmp_valid, cmp_fail, peer_go, peer_halt, peer_fail} = '0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_jump();
        t_err();
        t_stst();
        t_group();
        t_clock();
        conclude();
    end
endmodule
`default_nettype wire
